//--- src/pqt_defines.svh
// Register indices, field positions, codes and prescale values for the timer block
`ifndef PQT_DEFINES_SVH
`define PQT_DEFINES_SVH

`define PQT_ADDR_W 5
`define PQT_IDX_CTRL_A 5'h0c
`define PQT_IDX_CTRL_B 5'h0d
`define PQT_IDX_CTRL_CD 5'h0e
`define PQT_IDX_CONST_A 5'h0f
`define PQT_IDX_CONST_B 5'h10
`define PQT_IDX_CONST_C 5'h11
`define PQT_IDX_CONST_D 5'h12

`define PQT_CTRL_RESET_BIT 4
`define PQT_CD_C_LSB 4
`define PQT_CD_D_LSB 0

`define PQT_MODE_STOP 4'h0
`define PQT_MODE_EVENT 4'h8

`define PQT_DIV_1 8'h04
`define PQT_DIV_2 8'h0a
`define PQT_DIV_3 8'h10
`define PQT_DIV_4 8'h32
`define PQT_DIV_5 8'h40
`define PQT_DIV_6 8'h64
`define PQT_DIV_7 8'hc8

`define PQT_RELOAD_AT 8'h01
`define PQT_BYTE_ZERO 8'h00

`endif

//--- src/pqt_pkg.sv
// Types and shared decoding for the prescaled timer block
package pqt_pkg;
`include "pqt_defines.svh"

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_ACK
    } pqt_bus_e;

    typedef logic [7:0] pqt_byte_t;

    // Prescale divisor from the low three mode bits
    function automatic pqt_byte_t prescale_div(input logic [2:0] code);
        pqt_byte_t d;
        d = `PQT_DIV_7;
        case (code)
            3'h1: d = `PQT_DIV_1;
            3'h2: d = `PQT_DIV_2;
            3'h3: d = `PQT_DIV_3;
            3'h4: d = `PQT_DIV_4;
            3'h5: d = `PQT_DIV_5;
            3'h6: d = `PQT_DIV_6;
            default: d = `PQT_DIV_7;
        endcase
        return d;
    endfunction
endpackage

//--- src/pqt_timer_if.sv
// Link between the register front end and one timer core
`timescale 1ns/100ps
interface pqt_timer_if;
    logic [3:0] mode;
    logic [7:0] wrData;
    logic wrConst;
    logic forceLow;
    logic aux;
    logic edgeSel;
    logic [7:0] count;
    logic timeout;
    logic outLevel;

    modport ctrl (
        output mode, wrData, wrConst, forceLow, aux, edgeSel,
        input count, timeout, outLevel
    );
    modport timer (
        input mode, wrData, wrConst, forceLow, aux, edgeSel,
        output count, timeout, outLevel
    );
endinterface

//--- src/pqt_timer.sv
// One prescaler plus eight-bit down counter timer
`timescale 1ns/100ps
`include "pqt_defines.svh"
module pqt_timer #(
    parameter bit FULL = 1'b1
) (
    input wire logic clock,
    input wire logic rst_n,
    pqt_timer_if.timer tif
);
    logic [7:0] pre;
    logic [7:0] next_pre;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [7:0] tconst;
    logic [7:0] next_tconst;
    logic outLvl;
    logic next_outLvl;
    logic tmo;
    logic next_tmo;
    logic prevAct;
    logic next_prevAct;
    logic [7:0] div;
    logic auxAct;
    logic isDelay;
    logic isEvent;
    logic isPulse;
    logic run;
    logic countPulse;

    always_comb begin
        auxAct = FULL & (tif.aux ~^ tif.edgeSel);
        isEvent = FULL & (tif.mode == `PQT_MODE_EVENT);
        isPulse = FULL & tif.mode[3] & ~isEvent;
        isDelay = ~tif.mode[3] & (tif.mode != `PQT_MODE_STOP);
        run = isDelay | (isPulse & auxAct);
        div = pqt_pkg::prescale_div(tif.mode[2:0]);
        next_prevAct = auxAct;
        next_pre = `PQT_BYTE_ZERO;
        countPulse = 1'b0;
        if (run) begin
            if (pre >= div - 8'h01) begin
                countPulse = 1'b1;
            end else begin
                next_pre = pre + 8'h01;
            end
        end
        if (isEvent) begin
            countPulse = auxAct & ~prevAct;
        end
        next_tconst = tconst;
        next_cnt = cnt;
        next_tmo = 1'b0;
        if (countPulse) begin
            if (cnt == `PQT_RELOAD_AT) begin
                next_cnt = tconst;
                next_tmo = 1'b1;
            end else begin
                next_cnt = cnt - 8'h01;
            end
        end
        if (tif.wrConst) begin
            next_tconst = tif.wrData;
            if (tif.mode == `PQT_MODE_STOP) begin
                next_cnt = tif.wrData;
            end
        end
        if (tif.forceLow) begin
            next_outLvl = 1'b0;
        end else begin
            next_outLvl = tmo ? ~outLvl : outLvl;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pre <= `PQT_BYTE_ZERO;
            tmo <= 1'b0;
            outLvl <= 1'b0;
            prevAct <= 1'b0;
        end else begin
            pre <= next_pre;
            tmo <= next_tmo;
            outLvl <= next_outLvl;
            prevAct <= next_prevAct;
        end
    end

    // Counter and constant keep their contents through reset
    always_ff @(posedge clock) begin
        cnt <= next_cnt;
        tconst <= next_tconst;
    end

    assign tif.count = cnt;
    assign tif.timeout = tmo;
    assign tif.outLevel = outLvl;
endmodule

//--- src/pqt_top.sv
// Four prescaled timers behind the parallel register bus
// Behaviour
// - Four timers; A and B full function, C and D delay only.
// - All timers run from one timer clock, prescaler feeding main counter.
// - Each time-out inverts the timer output, which holds until next time-out.
// - Four-bit A/B mode: 0 stop, 1-7 delay, 8 event, 9-15 pulse width.
// - Control bit 4 is output reset; upper three bits read zero.
// - Stopped timer holds its count and loses any prescaler residue.
// - Delay mode prescaler always runs, one count pulse per divide period.
// - Main counter is an eight-bit binary down counter.
// - At 01 the next pulse reloads from the constant and makes a time-out.
// - Each time-out goes to the timer's interrupt channel.
// - Reads return the count held when the strobe was last high.
// - Writing a stopped timer loads both constant and counter.
// - Writing a running timer reaches the counter only at the next reload.
// - Constant 01 times out every pulse; 00 acts as 256.
// - Prescale change may misplace the first time-out; later ones are correct.
// - Event and pulse width modes use aux input A or B.
// - Pulse width mode runs the timer only while aux input is active.
// - Aux active level comes from the channel's edge-select bit.
// - Aux-related interrupt channels stay in use in pulse width mode.
// - Time-outs of C and D serve as serial baud clock sources.
// - Edge bit one means active high; zero means active low.
// - In pulse width mode the aux channel sees the opposite transition.
// - Event mode bypasses the prescaler, counting active aux transitions.
// - Writing output reset forces the output low during the write.
`timescale 1ns/100ps
`include "pqt_defines.svh"
module pqt_top (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic csN,
    input wire logic dsN,
    input wire logic readWrite,
    input wire logic [`PQT_ADDR_W-1:0] addr,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic dataOe,
    output logic dtackN,
    output logic dtackOe,
    input wire logic auxInA,
    input wire logic auxInB,
    input wire logic edgeSelA,
    input wire logic edgeSelB,
    output logic [3:0] timeout,
    output logic [3:0] timerOut,
    output logic [1:0] auxChan
);
    pqt_pkg::pqt_bus_e state;
    pqt_pkg::pqt_bus_e next_state;
    logic [4:0] ctrlA;
    logic [4:0] next_ctrlA;
    logic [4:0] ctrlB;
    logic [4:0] next_ctrlB;
    logic [2:0] modeC;
    logic [2:0] next_modeC;
    logic [2:0] modeD;
    logic [2:0] next_modeD;
    logic [7:0] next_dataOut;
    logic next_dataOe;
    logic next_dtackN;
    logic next_dtackOe;
    logic [`PQT_ADDR_W-1:0] accAddr;
    logic [`PQT_ADDR_W-1:0] next_accAddr;
    logic accWrite;
    logic next_accWrite;
    logic [7:0] accData;
    logic [7:0] next_accData;
    logic [1:0] next_auxChan;
    logic [7:0] hold [4];
    logic [7:0] next_hold [4];
    logic [7:0] counts [4];
    logic [3:0] wrConst;
    logic [1:0] forceLow;
    logic [1:0] pwMode;
    logic access;

    pqt_timer_if tif[4] ();

    // Register index of the constant for timer n
    function automatic logic [`PQT_ADDR_W-1:0] const_idx(input int n);
        logic [`PQT_ADDR_W-1:0] idx;
        idx = `PQT_IDX_CONST_A + n[`PQT_ADDR_W-1:0];
        return idx;
    endfunction

    // Pulse width codes are 9..15 on a full function timer
    function automatic logic is_pw(input logic [3:0] m);
        logic r;
        r = m[3] & (m != `PQT_MODE_EVENT);
        return r;
    endfunction

    // Read data for a register index
    function automatic logic [7:0] read_reg(
        input logic [`PQT_ADDR_W-1:0] a,
        input logic [4:0] ca,
        input logic [4:0] cb,
        input logic [2:0] mc,
        input logic [2:0] md,
        input logic [7:0] h0,
        input logic [7:0] h1,
        input logic [7:0] h2,
        input logic [7:0] h3
    );
        logic [7:0] r;
        r = `PQT_BYTE_ZERO;
        case (a)
            `PQT_IDX_CTRL_A: r = {3'h0, ca};
            `PQT_IDX_CTRL_B: r = {3'h0, cb};
            `PQT_IDX_CTRL_CD: r = {1'b0, mc, 1'b0, md};
            `PQT_IDX_CONST_A: r = h0;
            `PQT_IDX_CONST_B: r = h1;
            `PQT_IDX_CONST_C: r = h2;
            `PQT_IDX_CONST_D: r = h3;
            default: r = `PQT_BYTE_ZERO;
        endcase
        return r;
    endfunction

    assign pwMode[0] = is_pw(ctrlA[3:0]);
    assign pwMode[1] = is_pw(ctrlB[3:0]);
    assign access = ~csN & ~dsN;

    // Bus front end
    always_comb begin
        next_state = state;
        next_ctrlA = ctrlA;
        next_ctrlB = ctrlB;
        next_modeC = modeC;
        next_modeD = modeD;
        next_dataOut = dataOut;
        next_dataOe = 1'b0;
        next_dtackN = 1'b1;
        next_dtackOe = 1'b0;
        next_accAddr = accAddr;
        next_accWrite = accWrite;
        next_accData = accData;
        wrConst = 4'h0;
        forceLow = 2'h0;
        case (state)
            pqt_pkg::BUS_IDLE: begin
                if (access) begin
                    next_state = pqt_pkg::BUS_ACK;
                    next_accAddr = addr;
                    next_accWrite = ~readWrite;
                    next_accData = dataIn;
                    next_dtackN = 1'b0;
                    next_dtackOe = 1'b1;
                    if (readWrite) begin
                        next_dataOe = 1'b1;
                        next_dataOut = read_reg(addr, ctrlA, ctrlB, modeC, modeD,
                            hold[0], hold[1], hold[2], hold[3]);
                    end else begin
                        case (addr)
                            `PQT_IDX_CTRL_A: next_ctrlA = dataIn[4:0];
                            `PQT_IDX_CTRL_B: next_ctrlB = dataIn[4:0];
                            `PQT_IDX_CTRL_CD: begin
                                next_modeC = dataIn[`PQT_CD_C_LSB +: 3];
                                next_modeD = dataIn[`PQT_CD_D_LSB +: 3];
                            end
                            default: begin
                            end
                        endcase
                        for (int n = 0; n < 4; n++) begin
                            wrConst[n] = (addr == const_idx(n));
                        end
                    end
                end
            end
            pqt_pkg::BUS_ACK: begin
                if (accWrite && accData[`PQT_CTRL_RESET_BIT]) begin
                    forceLow[0] = (accAddr == `PQT_IDX_CTRL_A);
                    forceLow[1] = (accAddr == `PQT_IDX_CTRL_B);
                end
                if (csN || dsN) begin
                    next_state = pqt_pkg::BUS_IDLE;
                end else begin
                    next_dtackN = 1'b0;
                    next_dtackOe = 1'b1;
                    next_dataOe = ~accWrite;
                end
            end
            default: next_state = pqt_pkg::BUS_IDLE;
        endcase
    end

    // Read holding registers follow the counters while the strobe is high
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            next_hold[n] = dsN ? counts[n] : hold[n];
        end
        next_auxChan[0] = pwMode[0] ? ~auxInA : auxInA;
        next_auxChan[1] = pwMode[1] ? ~auxInB : auxInB;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= pqt_pkg::BUS_IDLE;
            ctrlA <= 5'h00;
            ctrlB <= 5'h00;
            modeC <= 3'h0;
            modeD <= 3'h0;
            dataOut <= `PQT_BYTE_ZERO;
            dataOe <= 1'b0;
            dtackN <= 1'b1;
            dtackOe <= 1'b0;
            accAddr <= '0;
            accWrite <= 1'b0;
            accData <= `PQT_BYTE_ZERO;
            auxChan <= 2'h0;
            for (int n = 0; n < 4; n++) begin
                hold[n] <= `PQT_BYTE_ZERO;
            end
        end else begin
            state <= next_state;
            ctrlA <= next_ctrlA;
            ctrlB <= next_ctrlB;
            modeC <= next_modeC;
            modeD <= next_modeD;
            dataOut <= next_dataOut;
            dataOe <= next_dataOe;
            dtackN <= next_dtackN;
            dtackOe <= next_dtackOe;
            accAddr <= next_accAddr;
            accWrite <= next_accWrite;
            accData <= next_accData;
            auxChan <= next_auxChan;
            for (int n = 0; n < 4; n++) begin
                hold[n] <= next_hold[n];
            end
        end
    end

    // Timer cores, all on the one timer clock
    generate
        for (genvar i = 0; i < 4; i++) begin : g_tmr
            if (i == 0) begin : g_a
                assign tif[i].mode = ctrlA[3:0];
                assign tif[i].aux = auxInA;
                assign tif[i].edgeSel = edgeSelA;
                assign tif[i].forceLow = forceLow[0];
            end else if (i == 1) begin : g_b
                assign tif[i].mode = ctrlB[3:0];
                assign tif[i].aux = auxInB;
                assign tif[i].edgeSel = edgeSelB;
                assign tif[i].forceLow = forceLow[1];
            end else begin : g_cd
                assign tif[i].mode = {1'b0, (i == 2) ? modeC : modeD};
                assign tif[i].aux = 1'b0;
                assign tif[i].edgeSel = 1'b0;
                assign tif[i].forceLow = 1'b0;
            end
            assign tif[i].wrData = dataIn;
            assign tif[i].wrConst = wrConst[i];
            assign counts[i] = tif[i].count;
            assign timeout[i] = tif[i].timeout;
            assign timerOut[i] = tif[i].outLevel;

            pqt_timer #(
                .FULL(i < 2)
            ) u_timer (
                .clock(clock),
                .rst_n(rst_n),
                .tif(tif[i])
            );
        end
    endgenerate
endmodule

//--- verification/pqt_checker.sv
// Port-level assertions for the prescaled timer block
`timescale 1ns/100ps
`include "pqt_defines.svh"
module pqt_checker (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic csN,
    input wire logic dsN,
    input wire logic readWrite,
    input wire logic [`PQT_ADDR_W-1:0] addr,
    input wire logic [7:0] dataIn,
    input wire logic [7:0] dataOut,
    input wire logic dataOe,
    input wire logic dtackN,
    input wire logic dtackOe,
    input wire logic [3:0] timeout,
    input wire logic [3:0] timerOut
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_ack_answer: assert property (!csN && $fell(dsN) |=> !dtackN && dtackOe)
        else $error("access not acknowledged one cycle after start");
    a_ack_release: assert property (dtackOe && $rose(dsN) |=> dtackN && !dtackOe)
        else $error("acknowledge not released after strobe rose");
    a_read_drive: assert property (!csN && $fell(dsN) && readWrite |=> dataOe)
        else $error("read data not driven");
    a_bus_idle: assert property (csN [*2] |-> !dataOe && !dtackOe)
        else $error("bus driven while not selected");
    a_ctrl_upper: assert property (!csN && $fell(dsN) && readWrite &&
        (addr == `PQT_IDX_CTRL_A || addr == `PQT_IDX_CTRL_B) |=> dataOut[7:5] == 3'h0)
        else $error("unused control bits not zero");
    a_force_low: assert property (!csN && $fell(dsN) && !readWrite &&
        addr == `PQT_IDX_CTRL_A && dataIn[`PQT_CTRL_RESET_BIT] |-> ##[1:2] !timerOut[0])
        else $error("output not forced low by reset bit");
    a_tick_single: assert property (|timeout |=> (timeout & $past(timeout)) == 4'h0)
        else $error("time-out pulse longer than one cycle");
    a_out_toggle: assert property (timeout[2] |=> timerOut[2] != $past(timerOut[2]))
        else $error("output did not toggle on time-out");
    a_out_hold: assert property (!timeout[3] |=> $stable(timerOut[3]))
        else $error("output changed without time-out");
    a_reset_clear: assert property (disable iff (1'b0) !rst_n |=>
        timerOut == 4'h0 && timeout == 4'h0 && !dtackOe && !dataOe)
        else $error("outputs not cleared by reset");
endmodule

bind pqt_top pqt_checker pqt_checker_i (.clock(clock), .rst_n(rst_n), .csN(csN), .dsN(dsN),
    .readWrite(readWrite), .addr(addr), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .dtackN(dtackN), .dtackOe(dtackOe), .timeout(timeout), .timerOut(timerOut));

//--- verification/pqt_host_model.sv
// Bus master model of the host processor
`timescale 1ns/100ps
`include "pqt_defines.svh"
module pqt_host_model (
    input wire logic clock,
    output logic csN,
    output logic dsN,
    output logic readWrite,
    output logic [`PQT_ADDR_W-1:0] addr,
    output logic [7:0] dataIn,
    input wire logic [7:0] dataOut,
    input wire logic dataOe,
    input wire logic dtackN,
    input wire logic dtackOe
);
    // Acknowledge line has a pull-up
    wire logic ack = dtackOe ? !dtackN : 1'b0;

    initial begin
        csN = 1'b1;
        dsN = 1'b1;
        readWrite = 1'b1;
        addr = '0;
        dataIn = 8'h00;
    end

    // Hold stretches the strobe like a slow host
    task automatic access(input logic rw, input logic [`PQT_ADDR_W-1:0] a, input logic [7:0] d,
            input int hold, output logic [7:0] q, output logic ok);
        ok = 1'b0;
        q = 8'h00;
        @(posedge clock);
        csN <= 1'b0;
        dsN <= 1'b0;
        readWrite <= rw;
        addr <= a;
        dataIn <= rw ? ~dataIn : d;
        for (int n = 0; n < 16 && !ok; n++) begin
            @(posedge clock);
            ok = ack;
            q = dataOe ? dataOut : ~dataIn;
        end
        repeat (hold) @(posedge clock);
        csN <= 1'b1;
        dsN <= 1'b1;
        dataIn <= ~dataIn;
        repeat (3) @(posedge clock);
    endtask
endmodule

//--- verification/pqt_top_tb.sv
// Self-checking bench for the prescaled timer block
`timescale 1ns/100ps
`include "pqt_defines.svh"
module pqt_top_tb;
    logic clock;
    logic rst_n;
    logic csN, dsN, readWrite, dataOe, dtackN, dtackOe;
    logic [`PQT_ADDR_W-1:0] addr;
    logic [7:0] dataIn, dataOut, q, q1;
    logic [3:0] timeout, timerOut;
    logic [1:0] auxChan;
    logic auxInA, auxInB, edgeSelA, edgeSelB;
    int bad_count;
    int n_compared;
    int per;
    int hitsB = 0;

    pqt_top pqt_top_i (.clock(clock), .rst_n(rst_n), .csN(csN), .dsN(dsN),
        .readWrite(readWrite), .addr(addr), .dataIn(dataIn), .dataOut(dataOut),
        .dataOe(dataOe), .dtackN(dtackN), .dtackOe(dtackOe), .auxInA(auxInA),
        .auxInB(auxInB), .edgeSelA(edgeSelA), .edgeSelB(edgeSelB), .timeout(timeout),
        .timerOut(timerOut), .auxChan(auxChan));
    pqt_host_model pqt_host_model_i (.clock(clock), .csN(csN), .dsN(dsN),
        .readWrite(readWrite), .addr(addr), .dataIn(dataIn), .dataOut(dataOut),
        .dataOe(dataOe), .dtackN(dtackN), .dtackOe(dtackOe));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) begin
        if (timeout[1] === 1'b1) hitsB <= hitsB + 1;
    end

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic bad(input string m);
        bad_count++;
        $display("BAD %0t %s", $time, m);
    endtask

    function automatic logic miss(input logic c);
        n_compared++;
        return c !== 1'b0;
    endfunction

    task automatic xfer(input logic rw, input logic [`PQT_ADDR_W-1:0] a, input logic [7:0] d,
            input int hold, output logic [7:0] r);
        logic ok;
        pqt_host_model_i.access(rw, a, d, hold, r, ok);
        if (miss(ok !== 1'b1)) begin
            bad("access not acknowledged");
            complete_run();
        end
    endtask

    // Cycles from the call to the next time-out of timer i
    task automatic gap(input int i, input int lim);
        per = 1;
        while (timeout[i] !== 1'b1) begin
            @(posedge clock);
            per++;
            if (per > lim) begin
                bad("time-out wait ran out");
                complete_run();
            end
        end
        @(posedge clock);
    endtask

    task automatic regs_scn();
        xfer(1'b1, `PQT_IDX_CTRL_A, 8'h00, 0, q);
        if (miss(q !== 8'h00)) bad("control not cleared by reset");
        xfer(1'b0, `PQT_IDX_CTRL_A, 8'hf0, 0, q);
        xfer(1'b1, `PQT_IDX_CTRL_A, 8'h00, 0, q);
        if (miss(q !== 8'h10)) bad("control readback wrong");
        xfer(1'b0, `PQT_IDX_CTRL_A, 8'h00, 0, q);
        xfer(1'b1, 5'h1f, 8'h00, 0, q);
        if (miss(q !== 8'h00)) bad("unmapped read not zero");
    endtask

    task automatic codes_scn();
        int div [7] = '{4, 10, 16, 50, 64, 100, 200};
        for (int c = 1; c <= 7; c++) begin
            xfer(1'b0, `PQT_IDX_CTRL_CD, 8'h00, 0, q);
            xfer(1'b0, `PQT_IDX_CONST_C, 8'h01, 0, q);
            xfer(1'b0, `PQT_IDX_CTRL_CD, 8'(c << `PQT_CD_C_LSB), 0, q);
            gap(2, 500);
            gap(2, 500);
            if (miss(per != div[c-1])) bad("prescale period wrong");
        end
        xfer(1'b0, `PQT_IDX_CTRL_CD, 8'h00, 0, q);
        xfer(1'b0, `PQT_IDX_CONST_D, 8'h00, 0, q);
        xfer(1'b0, `PQT_IDX_CTRL_CD, 8'h01, 0, q);
        gap(3, 1100);
        gap(3, 1100);
        if (miss(per != 1024)) bad("constant zero not 256 pulses");
        xfer(1'b0, `PQT_IDX_CTRL_CD, 8'h00, 0, q);
    endtask

    task automatic delay_scn();
        xfer(1'b0, `PQT_IDX_CONST_A, 8'h03, 0, q);
        xfer(1'b1, `PQT_IDX_CONST_A, 8'h00, 0, q);
        if (miss(q !== 8'h03)) bad("stopped write missed counter");
        xfer(1'b0, `PQT_IDX_CTRL_A, 8'h01, 0, q);
        gap(0, 100);
        gap(0, 100);
        if (miss(per != 12)) bad("delay period wrong");
        // Written just after reload, far from count 01
        xfer(1'b0, `PQT_IDX_CONST_A, 8'h05, 0, q);
        gap(0, 100);
        if (miss(per >= 12)) bad("running write reached counter early");
        gap(0, 100);
        if (miss(per != 20)) bad("new constant not used after reload");
        @(posedge clock);
        if (timerOut[0] !== 1'b1) begin
            gap(0, 100);
            @(posedge clock);
        end
        xfer(1'b0, `PQT_IDX_CTRL_A, 8'h11, 4, q);
        if (miss(timerOut[0] !== 1'b0)) bad("output not forced low");
        gap(0, 100);
        @(posedge clock);
        if (miss(timerOut[0] !== 1'b1)) bad("toggle did not resume");
        xfer(1'b0, `PQT_IDX_CTRL_A, 8'h00, 0, q);
        xfer(1'b1, `PQT_IDX_CONST_A, 8'h00, 0, q1);
        repeat (40) @(posedge clock);
        xfer(1'b1, `PQT_IDX_CONST_A, 8'h00, 0, q);
        if (miss(q !== q1)) bad("stopped timer kept counting");
    endtask

    task automatic event_scn();
        int n0;
        xfer(1'b0, `PQT_IDX_CTRL_B, 8'h00, 0, q);
        for (int e = 0; e < 2; e++) begin
            edgeSelB <= e[0];
            auxInB <= !e[0];
            xfer(1'b0, `PQT_IDX_CONST_B, 8'h02, 0, q);
            xfer(1'b0, `PQT_IDX_CTRL_B, 8'h08, 0, q);
            n0 = hitsB;
            for (int k = 0; k < 2; k++) begin
                auxInB <= e[0];
                repeat (8) @(posedge clock);
                auxInB <= !e[0];
                repeat (8) @(posedge clock);
            end
            if (miss(hitsB - n0 != 1)) bad("event count wrong");
            if (miss(auxChan[1] !== auxInB)) bad("aux channel B not passed through");
            xfer(1'b0, `PQT_IDX_CTRL_B, 8'h00, 0, q);
        end
    endtask

    task automatic pw_scn();
        edgeSelA <= 1'b1;
        auxInA <= 1'b0;
        xfer(1'b0, `PQT_IDX_CONST_A, 8'h10, 0, q);
        xfer(1'b0, `PQT_IDX_CTRL_A, 8'h09, 0, q);
        repeat (40) @(posedge clock);
        xfer(1'b1, `PQT_IDX_CONST_A, 8'h00, 0, q);
        if (miss(q !== 8'h10)) bad("timer ran with aux inactive");
        auxInA <= 1'b1;
        repeat (40) @(posedge clock);
        if (miss(auxChan[0] !== 1'b0)) bad("aux channel not inverted");
        auxInA <= 1'b0;
        repeat (8) @(posedge clock);
        xfer(1'b1, `PQT_IDX_CONST_A, 8'h00, 0, q);
        if (miss(q < 8'h05 || q > 8'h07)) bad("pulse width count wrong");
        xfer(1'b0, `PQT_IDX_CTRL_A, 8'h00, 0, q);
        auxInA <= 1'b1;
        repeat (4) @(posedge clock);
        if (miss(auxChan[0] !== 1'b1)) bad("aux channel still inverted");
        // Timer B in pulse width mode with its aux input held inactive
        xfer(1'b0, `PQT_IDX_CTRL_B, 8'h0f, 0, q);
        repeat (4) @(posedge clock);
        if (miss(auxChan[1] !== !auxInB)) bad("aux channel B not inverted");
        xfer(1'b1, `PQT_IDX_CONST_B, 8'h00, 0, q);
        if (miss(q !== 8'h02)) bad("timer B ran with aux inactive");
        xfer(1'b0, `PQT_IDX_CTRL_B, 8'h00, 0, q);
    endtask

    initial begin
        rst_n = 1'b0;
        auxInA = 1'b0;
        auxInB = 1'b0;
        edgeSelA = 1'b0;
        edgeSelB = 1'b0;
        bad_count = 0;
        n_compared = 0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        regs_scn();
        codes_scn();
        delay_scn();
        event_scn();
        pw_scn();
        complete_run();
    end
endmodule
